// ### rtl/filter_route_pkg.sv
// constants for the acceptance filter enable and hit routing block
package filter_route_pkg;
    // =========================================================
    // register byte offsets
    localparam logic [7:0]  ENABLE_OFFSET     = 8'h00;
    localparam logic [7:0]  DEST_OFFSET       = 8'h04;
    localparam logic [7:0]  LAST_HIT_OFFSET   = 8'h08;
    // =========================================================
    // values after reset
    localparam logic [15:0] ENABLE_RESET      = 16'hFFFF;
    localparam logic [15:0] DEST_RESET        = 16'h0000;
    // =========================================================
    // field layout of the destination register
    localparam int          DEST_FIELD_WIDTH  = 4;
    localparam int          FILTER3_LSB       = 12;
    localparam int          FILTER2_LSB       = 8;
    localparam int          FILTER1_LSB       = 4;
    localparam int          FILTER0_LSB       = 0;
    localparam logic [3:0]  FIFO_CODE         = 4'hF;
    localparam logic [3:0]  LAST_POINTED      = 4'h3;
    // last hit register: [3:0] buffer, [4] fifo, [11:8] filter
    localparam int          LAST_FIFO_BIT     = 4;
    localparam int          LAST_FILTER_LSB   = 8;
endpackage

// ### rtl/can_filter_hit_routing.sv
// acceptance filter enable and hit routing with an apb register slave
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// Operation
// - one enable bit per filter, sixteen
// - pointer all ones routes hit to fifo
// - pointer 0 to 14 selects that buffer
// - filter 3 destination in bits 15-12
// - filter 2 destination in bits 11-8
// - filter 1 destination in bits 7-4
module can_filter_hit_routing
    import filter_route_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // hits from the compare logic
    input  wire logic        hit_valid,
    input  wire logic [3:0]  hit_filter,
    input  wire logic [3:0]  upper_destination,
    // routing decision
    output logic             store_valid,
    output logic             store_to_fifo,
    output logic [3:0]       store_buffer,
    output logic [3:0]       store_filter
);
    // =========================================================
    // registers
    logic [15:0] enable_reg;
    logic [15:0] dest_reg;
    logic        pready_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;
    logic        store_valid_reg;
    logic        store_to_fifo_reg;
    logic [3:0]  store_buffer_reg;
    logic [3:0]  store_filter_reg;

    function automatic logic [3:0] dest_field(input logic [15:0] ptr,
                                              input int          lsb);
        dest_field = ptr[lsb +: DEST_FIELD_WIDTH];
    endfunction

    // =========================================================
    // apb decode
    wire         access_phase = psel & penable;
    wire         bus_done     = access_phase & pready_reg;
    wire         read_now     = access_phase & ~pwrite & ~pready_reg;
    wire         hit_enable   = paddr == ENABLE_OFFSET;
    wire         hit_dest     = paddr == DEST_OFFSET;
    wire         hit_last     = paddr == LAST_HIT_OFFSET;
    wire         mapped       = hit_enable | hit_dest | hit_last;
    wire         wr_enable    = bus_done & pwrite & hit_enable;
    wire         wr_dest      = bus_done & pwrite & hit_dest;
    wire [31:0]  last_word    = {20'h00000, store_filter_reg, 3'h0,
                                 store_to_fifo_reg, store_buffer_reg};
    // unmapped reads return zero; the slave flags them with pslverr
    wire [31:0]  read_word    = hit_enable ? {16'h0000, enable_reg} :
                                hit_dest   ? {16'h0000, dest_reg} :
                                hit_last   ? last_word : 32'h00000000;

    // =========================================================
    // hit routing
    wire         filter_on    = enable_reg[hit_filter];
    wire [3:0]   f3_dest      = dest_field(dest_reg, FILTER3_LSB);
    wire [3:0]   f2_dest      = dest_field(dest_reg, FILTER2_LSB);
    wire [3:0]   f1_dest      = dest_field(dest_reg, FILTER1_LSB);
    wire [3:0]   f0_dest      = dest_field(dest_reg, FILTER0_LSB);
    // filters above three point through registers outside this block
    wire [3:0]   dest_code    = hit_filter == 4'h0 ? f0_dest :
                                hit_filter == 4'h1 ? f1_dest :
                                hit_filter == 4'h2 ? f2_dest :
                                hit_filter == 4'h3 ? f3_dest :
                                upper_destination;
    wire         accept       = hit_valid & filter_on;
    wire         to_fifo      = dest_code == FIFO_CODE;

    // a write and a hit in one cycle: the hit still sees the old value
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            enable_reg <= ENABLE_RESET;
            dest_reg   <= DEST_RESET;
        end else begin
            if (wr_enable) begin
                enable_reg <= pwdata[15:0];
            end
            if (wr_dest) begin
                dest_reg <= pwdata[15:0];
            end
        end
    end

    // one wait state so that read data can come from a flip-flop
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h00000000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= access_phase & ~pready_reg;
            prdata_reg  <= read_now ? read_word : 32'h00000000;
            pslverr_reg <= access_phase & ~pready_reg & ~mapped;
        end
    end

    // the other store fields hold so the last-hit word stays readable
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            store_valid_reg   <= 1'b0;
            store_to_fifo_reg <= 1'b0;
            store_buffer_reg  <= 4'h0;
            store_filter_reg  <= 4'h0;
        end else begin
            store_valid_reg <= accept;
            if (accept) begin
                store_to_fifo_reg <= to_fifo;
                store_buffer_reg  <= to_fifo ? 4'h0 : dest_code;
                store_filter_reg  <= hit_filter;
            end
        end
    end

    assign pready        = pready_reg;
    assign prdata        = prdata_reg;
    assign pslverr       = pslverr_reg;
    assign store_valid   = store_valid_reg;
    assign store_to_fifo = store_to_fifo_reg;
    assign store_buffer  = store_buffer_reg;
    assign store_filter  = store_filter_reg;

    // =========================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_disabled_drop: assert property (
        hit_valid && !enable_reg[hit_filter] |=> !store_valid)
        else $error("hit on a disabled filter was stored");
    a_enabled_store: assert property (
        hit_valid && enable_reg[hit_filter] |=> store_valid
            && store_filter == $past(hit_filter))
        else $error("hit on an enabled filter was lost");
    a_fifo_route: assert property (
        hit_valid && filter_on && hit_filter <= LAST_POINTED
            && dest_code == FIFO_CODE |=> store_to_fifo)
        else $error("all ones pointer did not reach the fifo");
    a_buffer_route: assert property (
        store_valid && !store_to_fifo |-> store_buffer != FIFO_CODE)
        else $error("numbered buffer carried the fifo code");
    a_f3_field: assert property (
        hit_valid && filter_on && hit_filter == 4'h3
            && dest_reg[15:12] != FIFO_CODE
            |=> store_buffer == $past(dest_reg[15:12]) && !store_to_fifo)
        else $error("filter 3 used the wrong field");
    a_f2_field: assert property (
        hit_valid && filter_on && hit_filter == 4'h2
            && dest_reg[11:8] != FIFO_CODE
            |=> store_buffer == $past(dest_reg[11:8]))
        else $error("filter 2 used the wrong field");
    a_f1_field: assert property (
        hit_valid && filter_on && hit_filter == 4'h1
            && dest_reg[7:4] != FIFO_CODE
            |=> store_buffer == $past(dest_reg[7:4]))
        else $error("filter 1 used the wrong field");
    a_f0_field: assert property (
        hit_valid && filter_on && hit_filter == 4'h0
            && dest_reg[3:0] != FIFO_CODE
            |=> store_buffer == $past(dest_reg[3:0]))
        else $error("filter 0 used the wrong field");
    a_enable_write: assert property (
        wr_enable |=> enable_reg == $past(pwdata[15:0]))
        else $error("enable write did not land");
    a_dest_write: assert property (
        wr_dest |=> dest_reg == $past(pwdata[15:0]))
        else $error("destination write did not land");
    a_buffer_number: assert property (
        hit_valid && filter_on && dest_code != FIFO_CODE
            |=> !store_to_fifo && store_buffer == $past(dest_code))
        else $error("numbered buffer differs from the pointer code");
    a_upper_route: assert property (
        hit_valid && filter_on && hit_filter > LAST_POINTED
            && upper_destination != FIFO_CODE
            |=> store_buffer == $past(upper_destination))
        else $error("upper filter ignored the outside pointer");
    a_disabled_hold: assert property (
        hit_valid && !filter_on
            |=> $stable(store_buffer) && $stable(store_filter))
        else $error("hit on a disabled filter changed the store fields");
    a_store_pulse: assert property (
        store_valid |-> $past(hit_valid))
        else $error("store pulse without a hit");
    // register bus timing: exactly one wait state per transfer
    a_one_wait: assert property (
        access_phase && !pready |=> pready)
        else $error("ready did not follow the wait state");
    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("ready stood for more than one cycle");
    a_bad_address: assert property (
        access_phase && !pready && !mapped |=> pready && pslverr)
        else $error("unmapped access did not raise the error");
    a_read_enable: assert property (
        access_phase && !pready && !pwrite && hit_enable
            |=> prdata == {16'h0000, $past(enable_reg)})
        else $error("enable register read back wrong");
    a_read_idle: assert property (
        !pready |-> prdata == 32'h00000000)
        else $error("read data stood outside a transfer");

    c_fifo_hit:   cover property (store_valid && store_to_fifo);
    c_buffer_hit: cover property (store_valid && store_buffer == 4'hE);
    c_drop_hit:   cover property (hit_valid && !filter_on);
    c_bad_addr:   cover property (pslverr && pready);
    c_upper_hit:  cover property (store_valid && store_filter > LAST_POINTED);
endmodule

// ### tb/can_filter_hit_routing_tb_top.sv
// bench for the acceptance filter enable and hit routing block
`timescale 1ns/10ps
module can_filter_hit_routing_tb_top
    import filter_route_pkg::*;
;
    // =========================================================
    // stimulus and observed signals
    logic        clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, hit_valid = 0, store_valid, store_to_fifo;
    logic [3:0]  hit_filter = 4'h0, upper_destination = 4'h0;
    logic [3:0]  store_buffer, store_filter;
    logic        err;
    int          num_errors = 0, tests_run = 0;
    can_filter_hit_routing i_can_filter_hit_routing (
        .clock             (clock),
        .rst_b             (rst_b),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .pready            (pready),
        .prdata            (prdata),
        .pslverr           (pslverr),
        .hit_valid         (hit_valid),
        .hit_filter        (hit_filter),
        .upper_destination (upper_destination),
        .store_valid       (store_valid),
        .store_to_fifo     (store_to_fifo),
        .store_buffer      (store_buffer),
        .store_filter      (store_filter)
    );
    initial forever #2 clock = ~clock;
    // =========================================================
    // bus cycle, hit and compare helpers
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        // no fixed latency assumed: only the watchdog ends a hung wait
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one hit pulse; routing result is due one edge later
    task automatic hit(input logic [3:0] f, input logic [3:0] u);
        @(posedge clock);
        hit_valid         <= 1'b1;
        hit_filter        <= f;
        upper_destination <= u;
        @(posedge clock);
        hit_valid <= 1'b0;
        #1;
    endtask
    function automatic logic [31:0] route(input logic [3:0] f,
                                          input logic [3:0] c);
        return {22'h0, 1'b1, c == 4'hF, (c == 4'hF) ? 4'h0 : c, f};
    endfunction
    function automatic logic [31:0] seen();
        return {22'h0, store_valid, store_to_fifo, store_buffer,
                store_filter};
    endfunction
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        close_out();
    end
    // =========================================================
    // tests
    initial begin
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        apb(1'h0, ENABLE_OFFSET, 32'h0);
        chk(rd, 32'h0000FFFF);
        chk({31'h0, err}, 32'h0);
        apb(1'h0, DEST_OFFSET, 32'h0);
        chk(rd, 32'h0);
        // upper half must be dropped on write
        apb(1'h1, DEST_OFFSET, 32'hFFFFFE50);
        apb(1'h0, DEST_OFFSET, 32'h0);
        chk(rd, 32'h0000FE50);
        apb(1'h0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test registers done");
        hit(4'h3, 4'h0);
        chk(seen(), route(4'h3, 4'hF));
        hit(4'h2, 4'h0);
        chk(seen(), route(4'h2, 4'hE));
        hit(4'h1, 4'h0);
        chk(seen(), route(4'h1, 4'h5));
        hit(4'h0, 4'h0);
        chk(seen(), route(4'h0, 4'h0));
        hit(4'h7, 4'h9);
        chk(seen(), route(4'h7, 4'h9));
        // last-hit word: filter in [11:8], fifo in [4], buffer in [3:0]
        apb(1'h0, LAST_HIT_OFFSET, 32'h0);
        chk(rd, 32'h00000709);
        $display("test routing done");
        apb(1'h1, ENABLE_OFFSET, 32'h0000FFFB);
        apb(1'h0, ENABLE_OFFSET, 32'h0);
        chk(rd, 32'h0000FFFB);
        // dropped hit: no pulse, fields keep filter 7 and buffer 9
        hit(4'h2, 4'h0);
        chk(seen(), 32'h00000097);
        hit(4'h3, 4'h0);
        chk(seen(), route(4'h3, 4'hF));
        apb(1'h1, ENABLE_OFFSET, 32'h0000FFFF);
        hit(4'h2, 4'h0);
        chk(seen(), route(4'h2, 4'hE));
        $display("test enables done");
        // reset in mid-run brings registers and outputs back
        @(posedge clock);
        rst_b <= 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        chk(seen(), 32'h0);
        apb(1'h0, ENABLE_OFFSET, 32'h0);
        chk(rd, 32'h0000FFFF);
        apb(1'h0, DEST_OFFSET, 32'h0);
        chk(rd, 32'h0);
        hit(4'h1, 4'h0);
        chk(seen(), route(4'h1, 4'h0));
        $display("test reset done");
        close_out();
    end
endmodule
